// ===== rct_clk_sync.sv
`timescale 1ns/1ps
`default_nettype none
`include "rct_defs.svh"

module rct_clk_sync #(
  parameter int SYS_DIV = `RCT_SYS_DIV,
  parameter int RTC_DIV = `RCT_RTC_DIV
) (
  input wire logic clk_i, // System clock
  input wire logic rst_i, // Synchronous reset
  input wire logic ce_i, // Clock enable
  input wire logic rtc_clk_i, // Real-time clock oscillator
  input wire logic cmp_i, // Comparator output
  output rct_pkg::rct_ticks_t ticks_o // Count events
);
  import rct_pkg::*;

  localparam int SW = $clog2(SYS_DIV);
  localparam int RW = $clog2(RTC_DIV);

  logic [1:0] rtc_sync_reg;
  logic [1:0] cmp_sync_reg;
  logic rtc_last_reg;
  logic cmp_last_reg;
  logic [SW-1:0] sys_cnt_reg;
  logic [RW-1:0] rtc_cnt_reg;
  rct_ticks_t ticks_reg;

  // Only stage 1 feeds edge detection; stage 0 is read by stage 1 alone
  wire rtc_rise = rtc_sync_reg[1] & ~rtc_last_reg;
  wire cmp_rise = cmp_sync_reg[1] & ~cmp_last_reg;
  wire sys_wrap = (sys_cnt_reg == SW'(SYS_DIV - 1));
  wire rtc_wrap = (rtc_cnt_reg == RW'(RTC_DIV - 1));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rtc_sync_reg <= 2'h0;
      cmp_sync_reg <= 2'h0;
      rtc_last_reg <= 1'b0;
      cmp_last_reg <= 1'b0;
      sys_cnt_reg <= '0;
      rtc_cnt_reg <= '0;
      ticks_reg <= '0;
    end else if (ce_i) begin
      rtc_sync_reg <= {rtc_sync_reg[0], rtc_clk_i}; // [RULE3]
      cmp_sync_reg <= {cmp_sync_reg[0], cmp_i}; // [RULE3]
      rtc_last_reg <= rtc_sync_reg[1];
      cmp_last_reg <= cmp_sync_reg[1];
      sys_cnt_reg <= sys_wrap ? '0 : sys_cnt_reg + SW'(1);
      if (rtc_rise) begin
        rtc_cnt_reg <= rtc_wrap ? '0 : rtc_cnt_reg + RW'(1);
      end
      ticks_reg.sys_div <= sys_wrap; // [RULE3]
      ticks_reg.rtc_div <= rtc_rise & rtc_wrap; // [RULE3]
      ticks_reg.cmp_rise <= cmp_rise;
    end
  end

  assign ticks_o = ticks_reg;

endmodule // rct_clk_sync

`default_nettype wire

// ===== rct_defs.svh
`ifndef RCT_DEFS_SVH
`define RCT_DEFS_SVH

// ---------------------------------------------------------------
// Register byte offsets (32-bit word per register)
// ---------------------------------------------------------------
`define RCT_OFF_CNT_LO 5'h00
`define RCT_OFF_CNT_HI 5'h04
`define RCT_OFF_RLD_LO 5'h08
`define RCT_OFF_RLD_HI 5'h0C
`define RCT_OFF_CTRL 5'h10
`define RCT_OFF_CLKCTL 5'h14
`define RCT_OFF_IEN 5'h18

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define RCT_CLK_LO_SYS 0
`define RCT_CLK_HI_SYS 1
`define RCT_IEN_TIMER 0
`define RCT_XCLK_CAP 1

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define RCT_RST_BYTE 8'h00
`define RCT_RST_WORD 16'h0000
`define RCT_RST_CLK 2'h0

// ---------------------------------------------------------------
// Timing counts
// ---------------------------------------------------------------
`define RCT_SYS_DIV 12
`define RCT_RTC_DIV 8

`endif

// ===== rct_pkg.sv
package rct_pkg;

  // Control register layout, bit 7 down to bit 0
  typedef struct packed {
    logic high_overflow_flag;
    logic low_overflow_flag;
    logic low_byte_irq_enable;
    logic capture_enable;
    logic split_mode_select;
    logic run_control;
    logic [1:0] external_clock_select;
  } rct_ctrl_t;

  // Synchronised one-cycle count events
  typedef struct packed {
    logic sys_div;
    logic rtc_div;
    logic cmp_rise;
  } rct_ticks_t;

endpackage

// ===== rct_timer.sv
// How it works
// RULE1: Sixteen-bit counter from two byte registers
// RULE2: Split bit chooses one 16-bit or two 8-bit
// RULE3: Four sources; slow ones synchronised to clock
// RULE4: 16-bit wrap reloads and sets high flag
// RULE5: Timer enable requests interrupt on overflow
// RULE6: Low-byte enable adds low rollover interrupt
// RULE7: Split halves reload from own reload byte
// RULE8: Run gates high half only in split
// RULE9: Per-half system_clock select, else external field
// RULE10: Split: each half rollover sets its flag
// RULE11: Split interrupt on high, or either half
// RULE12: Flags cleared only by software writes
// RULE13: Software checks both flags on shared interrupt
// RULE14: Capture mode entered by capture-enable bit
// RULE15: Capture on comparator rise or rtc/8
// RULE16: System_clock count with rtc/8 capture allowed
// RULE17: Capture copies count to reload, sets flag
// RULE18: Software takes period from capture differences
// RULE19: Low flag on low rollover in any mode
// RULE20: Run bit gates whole 16-bit counter
//
// Decided for this implementation: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
`include "rct_defs.svh"

module rct_timer (
  input wire logic clk_i, // System clock, 100 MHz
  input wire logic rst_i, // Synchronous reset, active high
  input wire logic ce_i, // Clock enable, freezes all state
  input wire logic rtc_clk_i, // Real-time clock oscillator
  input wire logic cmp_i, // Comparator output
  input wire logic wb_cyc_i, // Wishbone cycle
  input wire logic wb_stb_i, // Wishbone strobe
  input wire logic wb_we_i, // Wishbone write enable
  input wire logic [31:0] wb_adr_i, // Wishbone byte address
  input wire logic [3:0] wb_sel_i, // Wishbone byte select
  input wire logic [31:0] wb_dat_i, // Wishbone write data
  output logic [31:0] wb_dat_o, // Wishbone read data
  output logic wb_ack_o, // Wishbone acknowledge
  output logic irq_o // Timer interrupt request
);
  import rct_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic [15:0] count_reg;
  logic [15:0] count_next;
  logic [15:0] reload_reg;
  logic [15:0] reload_next;
  rct_ctrl_t ctrl_reg;
  rct_ctrl_t ctrl_next;
  logic [1:0] clkctl_reg;
  logic ien_reg;
  logic ack_reg;
  logic [31:0] dat_reg;
  logic irq_reg;
  rct_ticks_t ticks;

  // ---------------------------------------------------------------
  // Source events
  // ---------------------------------------------------------------
  rct_clk_sync #(
    .SYS_DIV(`RCT_SYS_DIV),
    .RTC_DIV(`RCT_RTC_DIV)
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .rtc_clk_i(rtc_clk_i),
    .cmp_i(cmp_i),
    .ticks_o(ticks)
  );

  wire [1:0] xclk = ctrl_reg.external_clock_select;
  wire ext_tick = (xclk == 2'b00) ? ticks.sys_div :
                  (xclk == 2'b01) ? ticks.rtc_div :
                  (xclk == 2'b11) ? ticks.cmp_rise : 1'b0; // [RULE9]
  wire tick_lo = clkctl_reg[`RCT_CLK_LO_SYS] ? 1'b1 : ext_tick; // [RULE9] [RULE16]
  wire tick_hi = clkctl_reg[`RCT_CLK_HI_SYS] ? 1'b1 : ext_tick; // [RULE9]

  wire split = ctrl_reg.split_mode_select;
  wire run = ctrl_reg.run_control;
  wire [7:0] cnt_lo = count_reg[7:0];
  wire [7:0] cnt_hi = count_reg[15:8];

  // Capture source picked by upper external-select bit
  wire cap_src = xclk[`RCT_XCLK_CAP] ? ticks.cmp_rise : ticks.rtc_div; // [RULE15]
  wire cap_evt = ctrl_reg.capture_enable & cap_src; // [RULE14] [RULE15]

  // Roll-over events
  wire step16 = ~split & run & tick_lo; // [RULE20]
  wire step_lo = split ? tick_lo : step16; // [RULE8]
  wire step_hi = split & run & tick_hi; // [RULE8]
  wire ovf16 = step16 & (count_reg == 16'hFFFF); // [RULE4]
  wire ovf_lo = step_lo & (cnt_lo == 8'hFF); // [RULE19]
  wire ovf_hi = step_hi & (cnt_hi == 8'hFF); // [RULE10]
  wire set_h = ovf16 | ovf_hi | cap_evt; // [RULE4] [RULE10] [RULE17]
  wire set_l = ovf_lo; // [RULE10] [RULE19]

  // ---------------------------------------------------------------
  // Wishbone decode
  // ---------------------------------------------------------------
  wire wb_req = wb_cyc_i & wb_stb_i;
  wire wb_map = (wb_adr_i[31:5] == 27'h0000000) & (wb_adr_i[1:0] == 2'h0);
  wire [4:0] wb_off = wb_adr_i[4:0];
  wire wr_go = wb_req & wb_we_i & ack_reg & wb_map & wb_sel_i[0];
  wire [7:0] wb_byte = wb_dat_i[7:0];
  wire wr_cnt_lo = wr_go & (wb_off == `RCT_OFF_CNT_LO);
  wire wr_cnt_hi = wr_go & (wb_off == `RCT_OFF_CNT_HI);
  wire wr_rld_lo = wr_go & (wb_off == `RCT_OFF_RLD_LO);
  wire wr_rld_hi = wr_go & (wb_off == `RCT_OFF_RLD_HI);
  wire wr_ctrl = wr_go & (wb_off == `RCT_OFF_CTRL);
  wire wr_clk = wr_go & (wb_off == `RCT_OFF_CLKCTL);
  wire wr_ien = wr_go & (wb_off == `RCT_OFF_IEN);
  wire [7:0] rd_byte = ~wb_map ? 8'h00 :
                       (wb_off == `RCT_OFF_CNT_LO) ? cnt_lo :
                       (wb_off == `RCT_OFF_CNT_HI) ? cnt_hi :
                       (wb_off == `RCT_OFF_RLD_LO) ? reload_reg[7:0] :
                       (wb_off == `RCT_OFF_RLD_HI) ? reload_reg[15:8] :
                       (wb_off == `RCT_OFF_CTRL) ? ctrl_reg :
                       (wb_off == `RCT_OFF_CLKCTL) ? {6'h00, clkctl_reg} :
                       (wb_off == `RCT_OFF_IEN) ? {7'h00, ien_reg} : 8'h00;

  // ---------------------------------------------------------------
  // Counter, reload and flag next state
  // ---------------------------------------------------------------
  always_comb begin
    count_next = count_reg;
    if (step16) begin
      count_next = ovf16 ? reload_reg : count_reg + 16'h0001; // [RULE1] [RULE2] [RULE4]
    end
    if (split && step_lo) begin
      count_next[7:0] = ovf_lo ? reload_reg[7:0] : cnt_lo + 8'h01; // [RULE7]
    end
    if (step_hi) begin
      count_next[15:8] = ovf_hi ? reload_reg[15:8] : cnt_hi + 8'h01; // [RULE7]
    end
    if (wr_cnt_lo) begin
      count_next[7:0] = wb_byte; // [RULE1]
    end
    if (wr_cnt_hi) begin
      count_next[15:8] = wb_byte; // [RULE1]
    end
  end

  always_comb begin
    reload_next = reload_reg;
    if (wr_rld_lo) begin
      reload_next[7:0] = wb_byte;
    end
    if (wr_rld_hi) begin
      reload_next[15:8] = wb_byte;
    end
    if (cap_evt) begin
      reload_next = count_reg; // [RULE17]
    end
  end

  // Hardware set beats a software clear in the same cycle
  always_comb begin
    ctrl_next = wr_ctrl ? rct_ctrl_t'(wb_byte) : ctrl_reg;
    ctrl_next.high_overflow_flag = set_h | ctrl_next.high_overflow_flag; // [RULE12]
    ctrl_next.low_overflow_flag = set_l | ctrl_next.low_overflow_flag; // [RULE12]
  end

  // Shared request: high flag, or low flag when low enable is set
  wire irq_next = ien_reg & (ctrl_reg.high_overflow_flag |
                  (ctrl_reg.low_byte_irq_enable & ctrl_reg.low_overflow_flag)); // [RULE5] [RULE6] [RULE11]

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_reg <= `RCT_RST_WORD;
      reload_reg <= `RCT_RST_WORD;
      ctrl_reg <= rct_ctrl_t'(`RCT_RST_BYTE);
      clkctl_reg <= `RCT_RST_CLK;
      ien_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else if (ce_i) begin
      count_reg <= count_next;
      reload_reg <= reload_next;
      ctrl_reg <= ctrl_next;
      irq_reg <= irq_next;
      if (wr_clk) begin
        clkctl_reg <= wb_byte[1:0];
      end
      if (wr_ien) begin
        ien_reg <= wb_byte[`RCT_IEN_TIMER];
      end
    end
  end

  // Ack one cycle after request; write commits on the acked edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h00000000;
    end else if (ce_i) begin
      ack_reg <= wb_req & ~ack_reg;
      if (wb_req && !ack_reg) begin
        dat_reg <= {24'h000000, rd_byte};
      end
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;
  assign irq_o = irq_reg;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence ovf16_s;
    ce_i && !split && run && tick_lo && count_reg == 16'hFFFF && !wr_cnt_lo && !wr_cnt_hi;
  endsequence

  sequence lo_roll_s;
    ce_i && tick_lo && cnt_lo == 8'hFF && (split || run);
  endsequence

  sequence cap_s;
    ce_i && ctrl_reg.capture_enable &&
      (xclk[1] ? ticks.cmp_rise : ticks.rtc_div);
  endsequence

  wrap_reload_a: assert property (ovf16_s |=> count_reg == $past(reload_reg) && ctrl_reg.high_overflow_flag) // [RULE4]
    else $error("16-bit wrap did not reload or set high flag");

  irq_high_a: assert property (ce_i && ien_reg && ctrl_reg.high_overflow_flag |=> irq_o) // [RULE5]
    else $error("high flag with enable gave no request");

  irq_low_a: assert property (ce_i && ien_reg && ctrl_reg.low_byte_irq_enable && ctrl_reg.low_overflow_flag
    ##1 ce_i |-> irq_o) // [RULE6]
    else $error("low flag with both enables gave no request");

  irq_quiet_a: assert property (ce_i && !ien_reg |=> !irq_o) // [RULE11]
    else $error("request raised with timer interrupt disabled");

  split_reload_a: assert property (ce_i && split && run && tick_hi && cnt_hi == 8'hFF && !wr_cnt_hi
    |=> cnt_hi == $past(reload_reg[15:8])) // [RULE7]
    else $error("high half did not reload from its reload byte");

  split_low_run_a: assert property (ce_i && split && !run && tick_lo && cnt_lo != 8'hFF && !wr_cnt_lo
    |=> cnt_lo == $past(cnt_lo) + 8'h01) // [RULE8]
    else $error("low half stopped with run bit clear in split mode");

  low_flag_a: assert property (lo_roll_s |=> ctrl_reg.low_overflow_flag) // [RULE10] [RULE19]
    else $error("low rollover did not set low flag");

  flag_sticky_a: assert property (ce_i && ctrl_reg.high_overflow_flag && !wr_ctrl
    |=> ctrl_reg.high_overflow_flag) // [RULE12]
    else $error("high flag cleared without software write");

  capture_copy_a: assert property (cap_s |=> reload_reg == $past(count_reg) && ctrl_reg.high_overflow_flag) // [RULE17]
    else $error("capture did not copy count or set flag");

  run_hold_a: assert property (ce_i && !split && !run && !wr_cnt_lo && !wr_cnt_hi
    |=> count_reg == $past(count_reg)) // [RULE20]
    else $error("16-bit counter moved with run bit clear");

  sys_count_a: assert property (ce_i && !split && run && clkctl_reg[0] && count_reg != 16'hFFFF
    && !wr_cnt_lo && !wr_cnt_hi |=> count_reg == $past(count_reg) + 16'h0001) // [RULE9] [RULE16]
    else $error("system clock select did not count every cycle");

  ack_pulse_a: assert property (ce_i && wb_ack_o ##1 ce_i |-> !wb_ack_o)
    else $error("acknowledge held longer than one cycle");

  // ---------------------------------------------------------------
  // Mode, freeze and bus assertions
  // ---------------------------------------------------------------
  sequence hi_roll_s;
    ce_i && split && run && tick_hi && cnt_hi == 8'hFF;
  endsequence

  sequence wb_take_s;
    ce_i && wb_req && !ack_reg;
  endsequence

  high_flag_split_a: assert property (hi_roll_s
    |=> ctrl_reg.high_overflow_flag) // [RULE10]
    else $error("high half rollover did not set high flag");

  irq_split_a: assert property (hi_roll_s ##1 (ce_i && ien_reg)
    |=> irq_o) // [RULE11]
    else $error("high half rollover gave no request");

  ack_answer_a: assert property (wb_take_s
    |=> wb_ack_o)
    else $error("request taken but not acknowledged");

  rdata_upper_a: assert property (wb_ack_o
    |-> wb_dat_o[31:8] == 24'h000000)
    else $error("read data upper bits not zero");

  state_freeze_a: assert property (!ce_i
    |=> $stable(count_reg) && $stable(reload_reg) && $stable(ctrl_reg))
    else $error("state moved with clock enable low");

  bus_freeze_a: assert property (!ce_i
    |=> $stable(wb_ack_o) && $stable(wb_dat_o) && $stable(irq_o))
    else $error("outputs moved with clock enable low");

  hi_hold_a: assert property (ce_i && split && !run && !wr_cnt_hi
    |=> cnt_hi == $past(cnt_hi)) // [RULE8]
    else $error("high half moved with run bit clear");

  lo_split_reload_a: assert property (ce_i && split && tick_lo && cnt_lo == 8'hFF && !wr_cnt_lo
    |=> cnt_lo == $past(reload_reg[7:0])) // [RULE7]
    else $error("low half did not reload from its reload byte");

  cap_off_a: assert property (ce_i && !ctrl_reg.capture_enable && !wr_rld_lo && !wr_rld_hi
    |=> reload_reg == $past(reload_reg)) // [RULE14]
    else $error("reload changed outside capture mode");

  reserved_quiet_a: assert property (ce_i && xclk == 2'b10 && !clkctl_reg[0] && !split
    && !wr_cnt_lo && !wr_cnt_hi |=> count_reg == $past(count_reg)) // [RULE9]
    else $error("reserved source made the counter move");

  cmp_capture_a: assert property (ce_i && ctrl_reg.capture_enable && xclk[1] && ticks.cmp_rise
    |=> reload_reg == $past(count_reg)) // [RULE15]
    else $error("comparator rise did not capture the count");

  low_flag_sticky_a: assert property (ce_i && ctrl_reg.low_overflow_flag && !wr_ctrl
    |=> ctrl_reg.low_overflow_flag) // [RULE12]
    else $error("low flag cleared without software write");

  irq_low_quiet_a: assert property (ce_i && !ctrl_reg.high_overflow_flag
    && !ctrl_reg.low_byte_irq_enable |=> !irq_o) // [RULE6]
    else $error("request raised with no enabled flag");

  wr_count_a: assert property (ce_i && wr_cnt_lo
    |=> cnt_lo == $past(wb_byte)) // [RULE1]
    else $error("count low byte write did not land");

endmodule // rct_timer

`default_nettype wire

// ===== rct_timer_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "rct_defs.svh"

module rct_timer_tb_top;
  import rct_pkg::*;
  logic clk_i, rst_i, rtc_clk_i, cmp_i, cyc, stb, we, ack, irq, ce;
  logic [15:0] cap_a, cap_b;
  logic [31:0] adr, dat_w, dat_r;
  logic [3:0] sel;
  int n_errors, total_checks;
  logic [7:0] rd, vh, rlo, rhi;
  rct_ctrl_t c;
  int k;

  rct_timer rct_timer_i (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
    .rtc_clk_i(rtc_clk_i), .cmp_i(cmp_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w),
    .wb_dat_o(dat_r), .wb_ack_o(ack), .irq_o(irq));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // Slow oscillator, phase unrelated to the system clock
  initial begin
    rtc_clk_i = 1'b0;
    forever #23 rtc_clk_i = ~rtc_clk_i;
  end

  // ---------------------------------------------------------------
  // Bus and compare tasks
  // ---------------------------------------------------------------
  task automatic bus(input logic [4:0] a, input logic w, input logic [7:0] d,
                     input logic [3:0] s);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {27'h0, a};
    dat_w <= {24'h0, d};
    sel <= s;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 16);
    rd = dat_r[7:0];
    if (ack !== 1'b1) begin
      n_errors++;
      $display("MISMATCH wb_ack expected 1 seen %b", ack);
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    bus(a, 1'b1, d, 4'hF);
  endtask

  task automatic rdr(input logic [4:0] a);
    bus(a, 1'b0, 8'h00, 4'hF);
  endtask

  task automatic ctl(input logic hf, lf, len, cap, spl, run, input logic [1:0] x);
    c = '{hf, lf, len, cap, spl, run, x};
    wr(`RCT_OFF_CTRL, c);
  endtask

  task automatic check_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic check_bit(input string nm, input logic e, input logic g);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %b seen %b", nm, e, g);
    end
  endtask

  // Wait for a capture, read the captured pair, clear the flag
  task automatic grab(output logic [15:0] v);
    do rdr(`RCT_OFF_CTRL); while (rd[7] !== 1'b1);
    rdr(`RCT_OFF_RLD_LO);
    v[7:0] = rd;
    rdr(`RCT_OFF_RLD_HI);
    v[15:8] = rd;
    ctl(0, 0, 0, 1, 0, 1, 2'b00);
  endtask

  function automatic logic exp_irq(logic ien, logic len, logic hf, logic lf);
    return ien & (hf | (len & lf));
  endfunction

  function automatic int exp_cnt(logic [1:0] x, int cyc_n);
    if (x == 2'b00) return cyc_n / `RCT_SYS_DIV;
    if (x == 2'b01) return (cyc_n * 10) / (46 * `RCT_RTC_DIV);
    return 0;
  endfunction

  function automatic logic in_rng(logic [7:0] v, int lo, int hi);
    return (int'(v) >= lo) && (int'(v) <= hi);
  endfunction

  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge clk_i);
    n_errors++;
    close_out();
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    rst_i = 1'b1;
    ce = 1'b1;
    cmp_i = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 32'h0;
    dat_w = 32'h0;
    sel = 4'h0;
    n_errors = 0;
    total_checks = 0;
    void'($urandom(48));
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    for (k = 0; k <= 'h1C; k += 4) begin
      rdr(k[4:0]);
      check_byte("reset value", 8'h00, rd);
    end
    wr(5'h1C, 8'h5A);
    rdr(5'h1C);
    check_byte("unmapped", 8'h00, rd);
    rlo = 8'($urandom_range(0, 'h7F));
    rhi = 8'($urandom());
    wr(`RCT_OFF_CNT_LO, rlo);
    wr(`RCT_OFF_CNT_HI, rhi);
    repeat (20) @(posedge clk_i);
    rdr(`RCT_OFF_CNT_LO);
    check_byte("count lo held", rlo, rd);
    rdr(`RCT_OFF_CNT_HI);
    check_byte("count hi held", rhi, rd);
    // 16-bit wrap and reload
    wr(`RCT_OFF_CLKCTL, 8'h01);
    wr(`RCT_OFF_IEN, 8'h01);
    wr(`RCT_OFF_RLD_LO, rlo);
    bus(`RCT_OFF_RLD_LO, 1'b1, 8'hFF, 4'h0);
    wr(`RCT_OFF_RLD_HI, rhi);
    wr(`RCT_OFF_CNT_HI, 8'hFF);
    wr(`RCT_OFF_CNT_LO, 8'hE0);
    ctl(0, 0, 0, 0, 0, 1, 2'b00);
    repeat (60) @(posedge clk_i);
    rdr(`RCT_OFF_CTRL);
    check_byte("flags after wrap", 8'hC4, rd);
    check_bit("irq on wrap", exp_irq(1, 0, 1, 1), irq);
    ctl(1, 1, 0, 0, 0, 0, 2'b00);
    rdr(`RCT_OFF_CNT_HI);
    check_byte("reloaded hi", rhi, rd);
    repeat (50) @(posedge clk_i);
    rdr(`RCT_OFF_CTRL);
    check_byte("flags kept", 8'hC0, rd);
    ctl(0, 0, 0, 0, 0, 0, 2'b00);
    repeat (3) @(posedge clk_i);
    check_bit("irq cleared", 1'b0, irq);
    // Low-byte rollover in 16-bit mode
    wr(`RCT_OFF_CNT_HI, 8'h00);
    wr(`RCT_OFF_CNT_LO, 8'hF0);
    ctl(0, 0, 0, 0, 0, 1, 2'b00);
    repeat (40) @(posedge clk_i);
    rdr(`RCT_OFF_CTRL);
    check_byte("low flag only", 8'h44, rd);
    check_bit("no low irq", exp_irq(1, 0, 0, 1), irq);
    ctl(0, 1, 1, 0, 0, 0, 2'b00);
    repeat (3) @(posedge clk_i);
    check_bit("low irq", exp_irq(1, 1, 0, 1), irq);
    // Split mode: low half free running, high half gated
    vh = 8'($urandom());
    rlo = 8'($urandom_range(0, 'h7F));
    wr(`RCT_OFF_CLKCTL, 8'h03);
    wr(`RCT_OFF_CNT_HI, vh);
    wr(`RCT_OFF_RLD_LO, rlo);
    wr(`RCT_OFF_CNT_LO, 8'hFE);
    ctl(0, 0, 1, 0, 1, 0, 2'b00);
    repeat (20) @(posedge clk_i);
    rdr(`RCT_OFF_CNT_HI);
    check_byte("high half stopped", vh, rd);
    rdr(`RCT_OFF_CTRL);
    check_byte("split low flag", 8'h68, rd);
    check_bit("split low irq", exp_irq(1, 1, 0, 1), irq);
    rdr(`RCT_OFF_CNT_LO);
    check_bit("low reload", 1'b1, in_rng(rd, rlo, rlo + 'h40));
    rhi = 8'($urandom_range(0, 'hBF));
    wr(`RCT_OFF_RLD_HI, rhi);
    wr(`RCT_OFF_CNT_HI, 8'hFC);
    ctl(0, 0, 0, 0, 1, 1, 2'b00);
    repeat (20) @(posedge clk_i);
    rdr(`RCT_OFF_CTRL);
    check_bit("split high flag", 1'b1, rd[7]);
    check_bit("split high irq", exp_irq(1, 0, 1, 0), irq);
    rdr(`RCT_OFF_CNT_HI);
    check_bit("high reload", 1'b1, in_rng(rd, rhi, rhi + 'h30));
    // External sources in 16-bit mode
    wr(`RCT_OFF_CLKCTL, 8'h00);
    for (int e = 0; e < 3; e++) begin
      wr(`RCT_OFF_CNT_LO, 8'h00);
      wr(`RCT_OFF_CNT_HI, 8'h00);
      ctl(0, 0, 0, 0, 0, 1, e[1:0]);
      repeat (480) @(posedge clk_i);
      ctl(0, 0, 0, 0, 0, 0, e[1:0]);
      rdr(`RCT_OFF_CNT_LO);
      k = (e == 2) ? 0 : 3;
      check_bit("source rate", 1'b1,
        in_rng(rd, exp_cnt(e[1:0], 480) - k, exp_cnt(e[1:0], 480) + k));
    end
    wr(`RCT_OFF_CNT_LO, 8'h00);
    ctl(0, 0, 0, 0, 0, 1, 2'b11);
    k = $urandom_range(3, 9);
    repeat (k) begin
      repeat (6) @(posedge clk_i);
      cmp_i <= 1'b1;
      repeat (6) @(posedge clk_i);
      cmp_i <= 1'b0;
    end
    repeat (10) @(posedge clk_i);
    ctl(0, 0, 0, 0, 0, 0, 2'b11);
    rdr(`RCT_OFF_CNT_LO);
    check_byte("comparator count", 8'(k), rd);
    // Capture on comparator rise, then on slow clock
    wr(`RCT_OFF_CLKCTL, 8'h01);
    wr(`RCT_OFF_CNT_LO, 8'h00);
    ctl(0, 0, 0, 1, 0, 1, 2'b11);
    repeat (50) @(posedge clk_i);
    cmp_i <= 1'b1;
    repeat (20) @(posedge clk_i);
    rdr(`RCT_OFF_CTRL);
    check_bit("capture flag", 1'b1, rd[7]);
    check_bit("capture irq", 1'b1, irq);
    ctl(1, 0, 0, 1, 0, 0, 2'b11);
    rdr(`RCT_OFF_RLD_LO);
    check_bit("captured value", 1'b1, in_rng(rd, 48, 66));
    rdr(`RCT_OFF_RLD_HI);
    check_byte("captured hi", 8'h00, rd);
    ctl(0, 0, 0, 1, 0, 1, 2'b00);
    repeat (100) @(posedge clk_i);
    rdr(`RCT_OFF_CTRL);
    check_bit("slow capture flag", 1'b1, rd[7]);
    // Two successive slow captures: eight oscillator periods apart
    ctl(0, 0, 0, 1, 0, 1, 2'b00);
    grab(cap_a);
    grab(cap_b);
    check_bit("capture period", 1'b1,
      (16'(cap_b - cap_a) >= 16'h0023) && (16'(cap_b - cap_a) <= 16'h0027));
    // Clock enable low freezes the running counter
    rdr(`RCT_OFF_CNT_LO);
    vh = rd;
    ce <= 1'b0;
    repeat (20) @(posedge clk_i);
    ce <= 1'b1;
    rdr(`RCT_OFF_CNT_LO);
    check_byte("frozen count", 8'h03, 8'(rd - vh));
    close_out();
  end
endmodule // rct_timer_tb_top

`default_nettype wire
